// ---- dv/btq_master_model.sv ----
`timescale 1ns/1ps
module btq_master_model
    import btq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ready,
    input wire logic big,
    input wire logic [31:0] rnd,
    output logic [1:0] trans,
    output logic [ADDR_W-1:0] addr,
    output logic [2:0] size,
    output logic [2:0] burst,
    output logic write,
    output logic mastlock,
    output logic [DATA_W-1:0] wdata
);
    logic go;
    logic r;
    logic b;
    logic [31:0] v;
    initial {trans, addr, size, burst, write, mastlock, wdata} = '0;
    // read data unused; moves only after ready, or on reset
    // Everything sampled at the edge, so the bench's own updates never race
    always @(posedge sys_clk) begin
        {go, r, b, v} = {ready, rst, big, rnd};
        #1;
        if (r) begin
            {trans, mastlock} = {TRANS_IDLE, 1'h0};
        end else if (go && (trans == TRANS_IDLE || v[3:2] == 2'h0)) begin
            // idle, or new beat if unlocked
            trans = v[1] && !mastlock ? TRANS_NONSEQ : TRANS_IDLE;
            mastlock = trans[1] && v[7];
            addr = {v[31:12], 12'h000};
            size = b ? 3'h3 : {1'h0, v[5] & ~v[4], v[4]};
            {burst, write, wdata} = {BURST_INCR, v[6], v};
        end else if (go) begin
            addr = trans[1] ? addr + (ADDR_W'(1) << size) : addr;
            {trans, wdata} = {v[4] ? TRANS_BUSY : TRANS_SEQ, v};
        end
    end
endmodule

// ---- dv/btq_slave_assertions.sv ----
`timescale 1ns/1ps
module btq_slave_assertions
    import btq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] trans,
    input wire logic [2:0] size,
    input wire logic ready,
    input wire logic readyout,
    input wire logic resp,
    input wire logic xfer_valid,
    input wire logic [ADDR_W-1:0] xfer_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire hit = sel && ready, take = hit && trans[1];
    wire bad = take && size > SIZE_WORD, ok = readyout && !resp;
    chk_idle_okay: assert property (hit && trans == TRANS_IDLE |=> ok)
        else $error("idle not okay");
    chk_busy_okay: assert property (hit && trans == TRANS_BUSY |=> ok)
        else $error("busy not okay");
    chk_take_flag: assert property (take |=> xfer_valid)
        else $error("beat not flagged");
    chk_hold_off: assert property (!take |=> !xfer_valid)
        else $error("beat flagged");
    chk_addr_kept: assert property (take |=> xfer_addr == $past(addr))
        else $error("bad address");
    chk_legal_okay: assert property (take && !bad |=> ok)
        else $error("legal beat not okay");
    chk_size_error: assert property (
        bad |=> !readyout && resp ##1 readyout && resp) else $error("no error");
    chk_wait_error: assert property (!readyout |-> resp ##1 readyout)
        else $error("stray wait");
    cover property (bad);
    cover property (hit && trans == TRANS_BUSY);
    cover property (take ##1 take);
endmodule
bind btq_slave btq_slave_assertions u_chk (.*);

// ---- dv/bus_transfer_qualifier_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %0t: value mismatch", $time); end end
module bus_transfer_qualifier_bench;
    import btq_pkg::*;
    logic sys_clk = 0, rst = 1, big = 0, stall = 0, on = 0, p_take, p_lock;
    logic [31:0] seed = 32'h0000_0012, rnd = 32'h0000_0012;
    logic [1:0] trans, want = 2'h2;
    logic [2:0] size, burst, p_size, xfer_size;
    logic [ADDR_W-1:0] addr, p_addr, xfer_addr, xfer_expect;
    logic [DATA_W-1:0] wdata, rdata, wr_data, q_wdata;
    logic write, mastlock, readyout, resp, xfer_valid, xfer_locked;
    logic xfer_write, wr_strobe, seq_error, p_write, q_strb;
    int n_errors = 0, comparisons = 0;
    wire sel = !addr[13];
    wire ready = readyout !== 1'h0 && !stall;
    btq_slave DUT (.*);
    btq_master_model u_master (.*);
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Incrementing burst: next beat is size bytes on
    function automatic logic [31:0] beat_after(input logic [31:0] a,
        input logic [2:0] s);
        return a + (32'h0000_0001 << s);
    endfunction
    // Oversize beat: one wait cycle, then error again
    function automatic logic [1:0] answer(input logic t, e, input logic [2:0] s);
        return e ? 2'h3 : (t && s > SIZE_WORD) ? 2'h1 : 2'h2;
    endfunction
    task automatic wrap_up;
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Outputs compared before this edge's updates land
    always @(posedge sys_clk) begin
        if (on) begin
            `CHK(xfer_valid, p_take)
            `CHK({readyout, resp}, want)
            `CHK(wr_strobe, q_strb)
            `CHK(seq_error, 1'b0)
        end
        if (on && q_strb) begin
            `CHK(wr_data, q_wdata)
        end
        if (on && p_take) begin
            `CHK(xfer_addr, p_addr)
            `CHK({xfer_size, xfer_locked}, {p_size, p_lock})
            `CHK(xfer_write, p_write)
            `CHK(xfer_expect, beat_after(p_addr, p_size))
            `CHK(rdata, beat_after(p_addr, p_size) & 32'hffff_fffc)
        end
        // Write data lands one cycle after the accepted beat's data phase
        q_strb = !rst && p_take && p_write && p_size <= SIZE_WORD;
        q_wdata = wdata;
        p_take = !rst && sel && ready && trans[1];
        want = rst ? 2'h2 : answer(p_take, want == 2'h1, size);
        {p_addr, p_size, p_lock, p_write} = {addr, size, mastlock, write};
        on = 1'h1;
        #1;
        seed = xorshift(seed);
        {rnd, stall} = {seed, seed[9] & seed[10]};
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        repeat (300) @(posedge sys_clk);
        // Master breaks the bus width on purpose
        #1 big = 1;
        repeat (40) @(posedge sys_clk);
        #1 {big, rst} = 2'h1;
        @(posedge sys_clk);
        #1 rst = 0;
        repeat (300) @(posedge sys_clk);
        wrap_up;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_errors++;
        wrap_up;
    end
endmodule

// ---- verilog/btq_decode.sv ----
`timescale 1ns/1ps
module btq_decode
    import btq_pkg::*;
(
    btq_xfer_if.dec x,
    input wire logic sel,
    input wire logic ready
);
    // Bytes per beat from the size code
    function automatic logic [ADDR_W-1:0] size_bytes(input logic [2:0] s);
        size_bytes = {{(ADDR_W-1){1'b0}}, 1'b1} << s;
    endfunction
    // Beats in a wrapping burst: WRAP4/8/16 at codes 2/4/6
    function automatic logic [ADDR_W-1:0] wrap_beats(input logic [2:0] b);
        wrap_beats = {{(ADDR_W-3){1'b0}}, 3'h4} << (b[2:1] - 2'h1);
    endfunction

    wire logic is_active;
    wire logic is_wrap;
    wire logic [ADDR_W-1:0] span;
    wire logic [ADDR_W-1:0] next_lin;

    //RULE1 type decode
    assign is_active = x.trans[1];
    assign is_wrap = (x.burst != BURST_SINGLE) && !x.burst[0];
    //RULE15 wrap boundary
    assign span = size_bytes(x.size) * wrap_beats(x.burst);
    assign next_lin = x.addr + size_bytes(x.size);
    assign x.wrap_addr = is_wrap ?
        ((x.addr & ~(span - 1)) | (next_lin & (span - 1))) : next_lin;
    assign x.active = is_active;
    //RULE20 capture qualifier
    assign x.valid = sel && ready && is_active;
    //RULE13 size codes
    assign x.size_bad = x.size > SIZE_WORD;
endmodule

// ---- verilog/btq_pkg.sv ----
package btq_pkg;
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_BUSY = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ = 2'h3;
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR = 3'h1;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic RESP_OKAY = 1'b0;
    localparam logic RESP_ERROR = 1'b1;
    localparam logic [3:0] BEATS_SINGLE = 4'h1;
    typedef enum logic [2:0] {
        BTQ_IDLE = 3'b001,
        BTQ_BURST = 3'b010,
        BTQ_LOCKED = 3'b100
    } btq_state_t;
endpackage

// ---- verilog/btq_slave.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Transfer type codes: IDLE 00, BUSY 01, NONSEQ 10, SEQ 11.
// RULE2 - IDLE transfers are ignored, answered OKAY with no wait.
// RULE3 - Master drives IDLE whenever it wants no data transfer.
// RULE4 - Master should follow a locked sequence with an IDLE.
// RULE5 - BUSY pauses a burst; address already shows the next beat.
// RULE6 - Only undefined-length bursts may end on BUSY.
// RULE7 - BUSY transfers are ignored, answered OKAY with no wait.
// RULE8 - NONSEQ starts a burst or a lone one-beat transfer.
// RULE9 - SEQ beats keep control identical to the previous beat.
// RULE10 - SEQ address is previous plus size bytes, wrapping if wrap burst.
// RULE11 - Locked sequences complete before any other transaction is served.
// RULE12 - Multi-master slaves handle lock; in-order slaves may ignore it.
// RULE13 - Size codes 000..111 mean 8 up to 1024 bits.
// RULE14 - Master never requests a size above the 32-bit bus; the bench master asks for size code 3 (64 bits) while big is set.
// RULE15 - Wrap boundary comes from size and burst type together.
// RULE16 - Size has address timing and stays fixed during a burst.
// RULE17 - Master ignores read data in the data phase of BUSY.
// RULE18 - Act on a selected transfer only once ready shows completion.
// RULE19 - Response low means OKAY, high means ERROR.
// RULE20 - Capture only when select, ready high and type NONSEQ or SEQ.
module btq_slave
    import btq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] trans,
    input wire logic [2:0] size,
    input wire logic [2:0] burst,
    input wire logic write,
    input wire logic mastlock,
    input wire logic ready,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata,
    output logic readyout,
    output logic resp,
    output logic xfer_valid,
    output logic xfer_write,
    output logic [ADDR_W-1:0] xfer_addr,
    output logic [2:0] xfer_size,
    output logic [ADDR_W-1:0] xfer_expect,
    output logic xfer_locked,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_strobe,
    output logic seq_error
);
    btq_xfer_if x ();
    btq_state_t state;
    btq_state_t next_state;
    logic dphase;
    logic dphase_write;
    logic dphase_err;
    logic err_second;

    assign x.trans = trans;
    assign x.size = size;
    assign x.burst = burst;
    assign x.lock = mastlock;
    assign x.addr = addr;

    btq_decode u_dec (
        .x(x),
        .sel(sel),
        .ready(ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequence tracking
    // A SEQ beat is checked against the address this block predicted
    wire logic is_seq;
    wire logic seq_mismatch;
    wire logic bad_xfer;
    assign is_seq = trans == TRANS_SEQ;
    //RULE10 predicted address
    assign seq_mismatch = is_seq && (state == BTQ_IDLE ||
        addr != xfer_expect || size != xfer_size);
    //RULE13 oversize request
    assign bad_xfer = x.size_bad;

    always_comb begin
        next_state = state;
        case (state)
            BTQ_IDLE: begin
                //RULE8 burst start
                if (x.valid) begin
                    next_state = mastlock ? BTQ_LOCKED : BTQ_BURST;
                end
            end
            BTQ_BURST: begin
                if (sel && ready && trans == TRANS_IDLE) begin
                    next_state = BTQ_IDLE;
                end else if (x.valid && mastlock) begin
                    next_state = BTQ_LOCKED;
                end
            end
            BTQ_LOCKED: begin
                //RULE11 hold until lock drops
                if (ready && !mastlock) begin
                    next_state = x.valid ? BTQ_BURST : BTQ_IDLE;
                end
            end
            default: next_state = BTQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= BTQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xfer_valid <= 1'b0;
            xfer_write <= 1'b0;
            xfer_addr <= '0;
            xfer_size <= SIZE_BYTE;
            xfer_expect <= '0;
            xfer_locked <= 1'b0;
            seq_error <= 1'b0;
        end else begin
            // One-cycle strobe per accepted beat
            xfer_valid <= x.valid;
            seq_error <= x.valid && seq_mismatch;
            //RULE18 wait for ready
            if (x.valid) begin
                xfer_write <= write;
                xfer_addr <= addr;
                xfer_size <= size;
                xfer_expect <= x.wrap_addr;
                //RULE12 lock tracked
                xfer_locked <= mastlock;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data phase response
    // Errors take two cycles: HRESP high with ready low, then both high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dphase <= 1'b0;
            dphase_write <= 1'b0;
            dphase_err <= 1'b0;
            err_second <= 1'b0;
            readyout <= 1'b1;
            resp <= RESP_OKAY;
            wr_strobe <= 1'b0;
            wr_data <= '0;
            rdata <= '0;
        end else begin
            wr_strobe <= 1'b0;
            if (err_second) begin
                err_second <= 1'b0;
                readyout <= 1'b1;
                resp <= RESP_ERROR;
            end else if (x.valid) begin
                // RULE2 IDLE never reaches here
                dphase <= 1'b1;
                dphase_write <= write;
                dphase_err <= bad_xfer;
                //RULE19 error encoding
                if (bad_xfer) begin
                    readyout <= 1'b0;
                    resp <= RESP_ERROR;
                    err_second <= 1'b1;
                end else begin
                    readyout <= 1'b1;
                    resp <= RESP_OKAY;
                end
                rdata <= {x.wrap_addr[DATA_W-1:2], 2'b00};
            end else begin
                //RULE7 BUSY gets zero-wait OKAY
                dphase <= 1'b0;
                readyout <= 1'b1;
                resp <= RESP_OKAY;
                rdata <= '0;
            end
            // Write data arrives in the data phase
            if (dphase && dphase_write && !dphase_err) begin
                wr_strobe <= 1'b1;
                wr_data <= wdata;
            end
        end
    end
endmodule

// ---- verilog/btq_xfer_if.sv ----
`timescale 1ns/1ps
interface btq_xfer_if;
    import btq_pkg::*;
    logic valid;
    logic [1:0] trans;
    logic [2:0] size;
    logic [2:0] burst;
    logic lock;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] wrap_addr;
    logic active;
    logic size_bad;
    modport dec (input trans, size, burst, lock, addr,
                 output valid, wrap_addr, active, size_bad);
    modport top (output trans, size, burst, lock, addr,
                 input valid, wrap_addr, active, size_bad);
endinterface
